//--- common/plc_defs.vh
//
// Contract
// - Registers 32 bits, bit n is line n
// - Unimplemented lines ignore writes, read zero
// - Unmultiplexed lines always controller owned, read 1
// - Ownership enable ones give controller the line
// - Ownership disable ones hand line to peripheral
// - Ownership status: 0 peripheral, 1 controller
// - Drive enable ones set drive status
// - Drive disable ones clear drive status
// - Level status writable per sync write bit
// - Pin level reflects actual line levels
// - Change status resets to zero
// - A select clears, B select sets status
// - Ownership reset value configurable per line
// - Status registers other than ownership reset to zero
// - Level set/clear ones set/clear level bits
// - Direct level write only touches enabled bits
// - Change sets status; masked bit raises interrupt
// - Reading change status clears all pending bits
`ifndef PLC_DEFS_VH
`define PLC_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define PLC_LINE_CTRL_ENABLE 8'h00
`define PLC_LINE_CTRL_DISABLE 8'h04
`define PLC_LINE_CTRL_STATUS 8'h08
`define PLC_DRIVE_ENABLE 8'h10
`define PLC_DRIVE_DISABLE 8'h14
`define PLC_DRIVE_STATUS 8'h18
`define PLC_FILTER_ENABLE 8'h20
`define PLC_FILTER_DISABLE 8'h24
`define PLC_FILTER_STATUS 8'h28
`define PLC_LEVEL_SET 8'h30
`define PLC_LEVEL_CLEAR 8'h34
`define PLC_LEVEL_STATUS 8'h38
`define PLC_PIN_LEVEL 8'h3C
`define PLC_CHANGE_IRQ_ENABLE 8'h40
`define PLC_CHANGE_IRQ_DISABLE 8'h44
`define PLC_CHANGE_IRQ_MASK 8'h48
`define PLC_CHANGE_IRQ_STATUS 8'h4C
`define PLC_OPEN_DRAIN_ENABLE 8'h50
`define PLC_OPEN_DRAIN_DISABLE 8'h54
`define PLC_OPEN_DRAIN_STATUS 8'h58
`define PLC_PULLUP_DISABLE 8'h60
`define PLC_PULLUP_ENABLE 8'h64
`define PLC_PULLUP_STATUS 8'h68
`define PLC_FUNC_A_SELECT 8'h70
`define PLC_FUNC_B_SELECT 8'h74
`define PLC_FUNC_SELECT_STATUS 8'h78
`define PLC_SYNC_WRITE_ENABLE 8'hA0
`define PLC_SYNC_WRITE_DISABLE 8'hA4
`define PLC_SYNC_WRITE_STATUS 8'hA8
// ****************************************
// Reset values
// ****************************************
`define PLC_STATUS_RESET 32'h00000000
`endif

//--- rtl/plc_top.v
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "plc_defs.vh"
module plc_top #(
   parameter [31:0] LINE_IMPL = 32'hFFFFFFFF,
   parameter [31:0] LINE_MUXED = 32'hFFFFFFFF,
   parameter [31:0] LINE_CTRL_RESET = 32'hFFFFFFFF
) (
   input wire mclk,
   input wire sys_rst,
   input wire [7:0] bus_addr,
   input wire [31:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output reg [31:0] bus_rdata,
   input wire [31:0] pin_in,
   output reg [31:0] pin_out,
   output reg [31:0] pin_oe,
   output reg [31:0] pullup_on,
   input wire [31:0] per_a_out,
   input wire [31:0] per_a_oe,
   input wire [31:0] per_b_out,
   input wire [31:0] per_b_oe,
   output reg [31:0] per_in,
   output reg irq
);

   // ****************************************
   // Write decode
   // ****************************************
   function wsel;
      input [7:0] a;
      input [7:0] off;
      input w;
      begin
         wsel = w && (a == off);
      end
   endfunction

   wire [31:0] wd = bus_wdata & LINE_IMPL;
   wire [31:0] fixed_ctrl = LINE_IMPL & ~LINE_MUXED;

   reg [31:0] ctrl_r, drive_r, filt_r, level_r, mask_r, chg_r, od_r, pu_r, ab_r, sw_r;
   reg [31:0] samp_r, filt_s_r, prev_r;
   reg prime_r;

   // ****************************************
   // Input sampling and glitch filter
   // ****************************************
   // Filter rises on two equal high samples, falls on any mismatched pair, holds on two lows; a rise costs one cycle of latency, a fall none
   wire [31:0] filt_val = (samp_r & pin_in) | (filt_s_r & ~(samp_r ^ pin_in));
   wire [31:0] cur_lvl = (filt_r & filt_s_r) | (~filt_r & samp_r);
   wire [31:0] change = prime_r ? ((cur_lvl ^ prev_r) & LINE_IMPL) : 32'h00000000;
   wire isr_rd = bus_rd && (bus_addr == `PLC_CHANGE_IRQ_STATUS);

   always @(posedge mclk) begin
      samp_r <= pin_in;
      filt_s_r <= filt_val;
      prev_r <= cur_lvl;
      if (sys_rst) begin
         prime_r <= 1'h0;
      end else begin
         prime_r <= 1'h1;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Strobes never overlap, so one pair at most acts per cycle
   reg [31:0] ctrl_nxt;
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wsel(bus_addr, `PLC_LINE_CTRL_ENABLE, bus_wr)) begin
         ctrl_nxt = ctrl_r | wd;
      end else if (wsel(bus_addr, `PLC_LINE_CTRL_DISABLE, bus_wr)) begin
         ctrl_nxt = ctrl_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_r <= LINE_CTRL_RESET & LINE_IMPL;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ****************************************
   // Drive enables
   // ****************************************
   // Kept even while a peripheral owns the line
   reg [31:0] drive_nxt;
   always @* begin
      drive_nxt = drive_r;
      if (wsel(bus_addr, `PLC_DRIVE_ENABLE, bus_wr)) begin
         drive_nxt = drive_r | wd;
      end else if (wsel(bus_addr, `PLC_DRIVE_DISABLE, bus_wr)) begin
         drive_nxt = drive_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         drive_r <= `PLC_STATUS_RESET;
      end else begin
         drive_r <= drive_nxt;
      end
   end

   // ****************************************
   // Glitch filter enables
   // ****************************************
   reg [31:0] filt_nxt;
   always @* begin
      filt_nxt = filt_r;
      if (wsel(bus_addr, `PLC_FILTER_ENABLE, bus_wr)) begin
         filt_nxt = filt_r | wd;
      end else if (wsel(bus_addr, `PLC_FILTER_DISABLE, bus_wr)) begin
         filt_nxt = filt_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         filt_r <= `PLC_STATUS_RESET;
      end else begin
         filt_r <= filt_nxt;
      end
   end

   // ****************************************
   // Output levels
   // ****************************************
   reg [31:0] level_nxt;
   always @* begin
      level_nxt = level_r;
      if (wsel(bus_addr, `PLC_LEVEL_SET, bus_wr)) begin
         level_nxt = level_r | wd;
      end else if (wsel(bus_addr, `PLC_LEVEL_CLEAR, bus_wr)) begin
         level_nxt = level_r & ~wd;
      end else if (wsel(bus_addr, `PLC_LEVEL_STATUS, bus_wr)) begin
         // One write avoids the transient of a set then clear pair
         level_nxt = (level_r & ~sw_r) | (wd & sw_r);
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         level_r <= `PLC_STATUS_RESET;
      end else begin
         level_r <= level_nxt;
      end
   end

   // ****************************************
   // Change interrupt mask
   // ****************************************
   reg [31:0] mask_nxt;
   always @* begin
      mask_nxt = mask_r;
      if (wsel(bus_addr, `PLC_CHANGE_IRQ_ENABLE, bus_wr)) begin
         mask_nxt = mask_r | wd;
      end else if (wsel(bus_addr, `PLC_CHANGE_IRQ_DISABLE, bus_wr)) begin
         mask_nxt = mask_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         mask_r <= `PLC_STATUS_RESET;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // ****************************************
   // Open drain enables
   // ****************************************
   reg [31:0] od_nxt;
   always @* begin
      od_nxt = od_r;
      if (wsel(bus_addr, `PLC_OPEN_DRAIN_ENABLE, bus_wr)) begin
         od_nxt = od_r | wd;
      end else if (wsel(bus_addr, `PLC_OPEN_DRAIN_DISABLE, bus_wr)) begin
         od_nxt = od_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         od_r <= `PLC_STATUS_RESET;
      end else begin
         od_r <= od_nxt;
      end
   end

   // ****************************************
   // Pull-up enables
   // ****************************************
   reg [31:0] pu_nxt;
   always @* begin
      pu_nxt = pu_r;
      if (wsel(bus_addr, `PLC_PULLUP_ENABLE, bus_wr)) begin
         pu_nxt = pu_r | wd;
      end else if (wsel(bus_addr, `PLC_PULLUP_DISABLE, bus_wr)) begin
         pu_nxt = pu_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         pu_r <= `PLC_STATUS_RESET;
      end else begin
         pu_r <= pu_nxt;
      end
   end

   // ****************************************
   // Peripheral function select
   // ****************************************
   // Inverted pair: the first register clears, the second sets
   reg [31:0] ab_nxt;
   always @* begin
      ab_nxt = ab_r;
      if (wsel(bus_addr, `PLC_FUNC_A_SELECT, bus_wr)) begin
         ab_nxt = ab_r & ~wd;
      end else if (wsel(bus_addr, `PLC_FUNC_B_SELECT, bus_wr)) begin
         ab_nxt = ab_r | wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         ab_r <= `PLC_STATUS_RESET;
      end else begin
         ab_r <= ab_nxt;
      end
   end

   // ****************************************
   // Synchronous write enables
   // ****************************************
   reg [31:0] sw_nxt;
   always @* begin
      sw_nxt = sw_r;
      if (wsel(bus_addr, `PLC_SYNC_WRITE_ENABLE, bus_wr)) begin
         sw_nxt = sw_r | wd;
      end else if (wsel(bus_addr, `PLC_SYNC_WRITE_DISABLE, bus_wr)) begin
         sw_nxt = sw_r & ~wd;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         sw_r <= `PLC_STATUS_RESET;
      end else begin
         sw_r <= sw_nxt;
      end
   end

   // ****************************************
   // Change status
   // ****************************************
   // New change wins over the clear-on-read, so no event is lost
   reg [31:0] chg_nxt;
   always @* begin
      chg_nxt = chg_r;
      if (isr_rd) begin
         chg_nxt = 32'h00000000;
      end
      chg_nxt = chg_nxt | change;
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         chg_r <= `PLC_STATUS_RESET;
      end else begin
         chg_r <= chg_nxt;
      end
   end

   // ****************************************
   // Read path and pin outputs
   // ****************************************
   wire [31:0] own = ctrl_r | fixed_ctrl;
   wire [31:0] p_out = (ab_r & per_b_out) | (~ab_r & per_a_out);
   wire [31:0] p_oe = (ab_r & per_b_oe) | (~ab_r & per_a_oe);
   wire [31:0] d_out = (own & level_r) | (~own & p_out);
   wire [31:0] d_oe = (own & drive_r) | (~own & p_oe);
   reg [31:0] rd_nxt;

   always @* begin
      rd_nxt = 32'h00000000;
      if (bus_addr == `PLC_LINE_CTRL_STATUS) begin
         rd_nxt = own;
      end else if (bus_addr == `PLC_DRIVE_STATUS) begin
         rd_nxt = drive_r;
      end else if (bus_addr == `PLC_FILTER_STATUS) begin
         rd_nxt = filt_r;
      end else if (bus_addr == `PLC_LEVEL_STATUS) begin
         rd_nxt = level_r;
      end else if (bus_addr == `PLC_PIN_LEVEL) begin
         rd_nxt = cur_lvl;
      end else if (bus_addr == `PLC_CHANGE_IRQ_MASK) begin
         rd_nxt = mask_r;
      end else if (bus_addr == `PLC_CHANGE_IRQ_STATUS) begin
         rd_nxt = chg_r;
      end else if (bus_addr == `PLC_OPEN_DRAIN_STATUS) begin
         rd_nxt = od_r;
      end else if (bus_addr == `PLC_PULLUP_STATUS) begin
         rd_nxt = pu_r;
      end else if (bus_addr == `PLC_FUNC_SELECT_STATUS) begin
         rd_nxt = ab_r;
      end else if (bus_addr == `PLC_SYNC_WRITE_STATUS) begin
         rd_nxt = sw_r;
      end
   end

   // Read data stand one cycle only, zero otherwise
   always @(posedge mclk) begin
      if (sys_rst) begin
         bus_rdata <= 32'h00000000;
      end else if (bus_rd) begin
         bus_rdata <= rd_nxt & LINE_IMPL;
      end else begin
         bus_rdata <= 32'h00000000;
      end
   end

   // ****************************************
   // Pad drive
   // ****************************************
   // Open drain: drive low only, release for a one
   always @(posedge mclk) begin
      if (sys_rst) begin
         pin_out <= 32'h00000000;
         pin_oe <= 32'h00000000;
      end else begin
         pin_out <= d_out & ~od_r & LINE_IMPL;
         pin_oe <= d_oe & ~(od_r & d_out) & LINE_IMPL;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         pullup_on <= 32'h00000000;
      end else begin
         pullup_on <= pu_r & LINE_IMPL;
      end
   end

   // ****************************************
   // Peripheral inputs and interrupt
   // ****************************************
   // Peripherals see the raw sample; the filter only feeds status
   always @(posedge mclk) begin
      if (sys_rst) begin
         per_in <= 32'h00000000;
      end else begin
         per_in <= samp_r;
      end
   end

   // One shared line for all masked changes
   always @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'h0;
      end else begin
         irq <= |(chg_r & mask_r);
      end
   end
endmodule

//--- bench/plc_top_assertions.sv
`timescale 1ns/1ps
module plc_chk #(
   parameter [31:0] LINE_IMPL = 32'hFFFFFFFF,
   parameter [31:0] LINE_MUXED = 32'hFFFFFFFF
) (
   input wire mclk,
   input wire sys_rst,
   input wire [7:0] bus_addr,
   input wire [31:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   input wire [31:0] bus_rdata,
   input wire [31:0] pin_in,
   input wire irq
);
   // ******
   // Checks
   // ******
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   AST_RSVD_ZERO: assert property (bus_rd && bus_addr == 8'h0C |=> bus_rdata == 0)
      else $error("reserved read not zero");
   AST_WO_ZERO: assert property (bus_rd && bus_addr == 8'h30 |=> bus_rdata == 0)
      else $error("write-only read not zero");
   AST_UNIMPL: assert property ((bus_rdata & ~LINE_IMPL) == 0)
      else $error("unimplemented bit set");
   AST_FIXED_OWN: assert property (bus_rd && bus_addr == 8'h08 |=>
      &(bus_rdata | ~(LINE_IMPL & ~LINE_MUXED))) else $error("fixed line not owned");
   AST_OWN_SET: assert property (bus_wr && bus_addr == 8'h00 ##1 !bus_wr ##1
      bus_rd && bus_addr == 8'h08 |=> (bus_rdata & $past(bus_wdata, 3) & LINE_IMPL)
      == ($past(bus_wdata, 3) & LINE_IMPL)) else $error("ownership not taken");
   AST_OWN_CLR: assert property (bus_wr && bus_addr == 8'h04 ##1 !bus_wr ##1
      bus_rd && bus_addr == 8'h08 |=> (bus_rdata & $past(bus_wdata, 3) & LINE_MUXED) == 0)
      else $error("ownership not released");
   AST_DRV_SET: assert property (bus_wr && bus_addr == 8'h10 ##1 !bus_wr ##1
      bus_rd && bus_addr == 8'h18 |=> (bus_rdata & $past(bus_wdata, 3) & LINE_IMPL)
      == ($past(bus_wdata, 3) & LINE_IMPL)) else $error("drive not set");
   AST_DRV_CLR: assert property (bus_wr && bus_addr == 8'h14 ##1 !bus_wr ##1
      bus_rd && bus_addr == 8'h18 |=> (bus_rdata & $past(bus_wdata, 3)) == 0)
      else $error("drive not cleared");
   // Pins held still so no change is still in flight through sampler
   AST_IRQ_CLR: assert property (bus_rd && bus_addr == 8'h4C && $stable(pin_in)
      && pin_in == $past(pin_in, 2) && pin_in == $past(pin_in, 4) |=> ##1 !irq)
      else $error("irq kept after status read");
   cover property (bus_rd && bus_addr == 8'h4C ##1 bus_rdata != 0);
   cover property ($rose(irq));
   cover property (bus_wr && bus_addr == 8'h38);
endmodule
bind plc_top plc_chk #(.LINE_IMPL(LINE_IMPL), .LINE_MUXED(LINE_MUXED)) i_plc_chk (
   .mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pin_in(pin_in), .irq(irq));

//--- bench/plc_pin_model.sv
`timescale 1ns/1ps
module plc_pin_model (
   input wire mclk,
   input wire [31:0] pin_out,
   input wire [31:0] pin_oe,
   input wire [31:0] pullup_on,
   input wire [31:0] ext_val,
   input wire [31:0] ext_en,
   output wire [31:0] pin_in
);
   // No keeper: a floating line shows the inverse of its last level
   reg [31:0] flt_r = 32'h0;
   always @(posedge mclk) begin
      flt_r <= ~pin_in;
   end
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pullup_on | flt_r));
endmodule

//--- bench/test_plc_top.sv
`timescale 1ns/1ps
module test_plc_top;
   logic mclk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, irq;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0, ext_val = 32'h5A, bus_rdata, pin_in, pin_out, pin_oe;
   logic [31:0] pullup_on, per_in, per_a = 32'h0000AAAA, per_b = 32'h00005555;
   logic [23:0] pr [0:6] = '{24'h101418, 24'h202428, 24'h404448, 24'h505458, 24'h646068,
      24'h747078, 24'hA0A4A8};
   int n_errors = 0, tests_run = 0, i;
   always #2.5 mclk = ~mclk;
   plc_top #(.LINE_IMPL(32'h7FFFFFFF), .LINE_MUXED(32'hFFFF0000),
      .LINE_CTRL_RESET(32'h00FF0000)) i_plc_top (.mclk(mclk), .sys_rst(sys_rst),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pullup_on), .per_a_out(per_a), .per_a_oe(per_b), .per_b_out(per_b),
      .per_b_oe(per_a), .per_in(per_in), .irq(irq));
   plc_pin_model i_plc_pin_model (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(32'hFFFFFFFF), .pin_in(pin_in));
   task automatic chk(input [31:0] got, input [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] exp);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1;
      chk(bus_rdata, exp);
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(8'h08, 32'h00FFFFFF);
      rd(8'h3C, 32'h5A);
      rd(8'h4C, 32'h0);
      rd(8'h38, 32'h0);
      for (i = 0; i < 7; i++) rd(pr[i][7:0], 32'h0);
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h08, 32'h0000FFFF);
      wr(8'h00, 32'h00F00000);
      rd(8'h08, 32'h00F0FFFF);
      for (i = 0; i < 7; i++) begin
         wr(pr[i][23:16], 32'hFFFFFFFF);
         rd(pr[i][7:0], 32'h7FFFFFFF);
         if (i == 4) chk(pullup_on, 32'h7FFFFFFF);
         rd(pr[i][23:16], 32'h0);
         wr(pr[i][15:8], 32'h0000FFFF);
         rd(pr[i][7:0], 32'h7FFF0000);
         wr(pr[i][15:8], 32'hFFFFFFFF);
         rd(pr[i][7:0], 32'h0);
      end
      // Driving then releasing the low lines toggled the ones of 0x5A twice
      rd(8'h4C, 32'h5A);
      wr(8'h30, 32'hF0);
      rd(8'h38, 32'hF0);
      wr(8'h34, 32'h30);
      rd(8'h38, 32'hC0);
      wr(8'hA0, 32'h0F);
      wr(8'h38, 32'hFFFFFFFF);
      rd(8'h38, 32'hCF);
      wr(8'h10, 32'hFF);
      repeat (4) @(posedge mclk);
      chk(pin_out, 32'hCF);
      chk(pin_oe, 32'hFF);
      chk(per_in, 32'hCF);
      chk(pullup_on, 32'h0);
      rd(8'h3C, 32'hCF);
      rd(8'h4C, 32'h95);
      rd(8'h4C, 32'h0);
      wr(8'h40, 32'h100);
      ext_val <= 32'h15A;
      repeat (5) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      rd(8'h4C, 32'h100);
      ext_val <= 32'h35A;
      repeat (5) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h4C, 32'h200);
      wr(8'h0C, 32'hFFFFFFFF);
      rd(8'h0C, 32'h0);
      rd(8'hFC, 32'h0);
      test_done;
   end
endmodule
